// ==== rtl/cpu_core_registers.sv ====
// Programmer-visible registers, program counter, flags and stack of the core
//
// Notes on behaviour
// [RULE1] Eight-bit accumulator, also a data-space byte at FFh.
// [RULE2] Two pointer registers at 80h and 81h, readable and writable.
// [RULE3] Two short-direct byte registers at 82h and 83h.
// [RULE4] Program counter is twelve bits, reaching 4096 program bytes.
// [RULE5] Beyond 4096 bytes only a separate bank register helps; PC never widens.
// [RULE6] Ordinary fetches advance the program counter by one.
// [RULE7] Jump, call, relative branch, vector and returns each load the PC.
// [RULE8] Three carry/zero pairs: main, interrupt and NMI contexts.
// [RULE9] Interrupt or NMI entry selects its pair; exit restores the previous.
// [RULE10] Pairs keep values over switches; only the active pair is visible.
// [RULE11] Active carry follows carry/borrow, tested bit, and feeds rotate-left.
// [RULE12] Active zero is set for a zero result, cleared otherwise.
// [RULE13] After reset the NMI pair is active until the first interrupt exit.
// [RULE14] Six twelve-bit levels of return stack, no pointer, strict LIFO.
// [RULE15] Call or interrupt shifts levels up; PC enters level one.
// [RULE16] Either return copies level one to PC and shifts levels down.
// [RULE17] Beyond six nestings the stack stays deepest; oldest address lost.
// [RULE18] Return on empty stack leaves it empty; execution continues sequentially.
// [RULE19] Software saves accumulator and data registers itself in subroutines.
// [RULE20] Any reset empties the stack and loads PC with vector 0FFEh.
// [RULE21] Context chain lets NMI exit return to interrupt, not main.
`timescale 1ns/1ps
module cpu_core_registers #(
  parameter int STACK_DEPTH = cpu_core_pkg::STACK_LEVELS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data-space bus
  input wire cpu_core_pkg::ds_req_t dsReq,
  output logic [7:0] dsRdData,
  output logic dsRdHit,
  // Accumulator port from the ALU
  input wire logic accWe,
  input wire logic [7:0] accIn,
  output logic [7:0] accOut,
  // Pointer and short-direct values
  output logic [7:0] firstPointer,
  output logic [7:0] secondPointer,
  output logic [7:0] shortSlotOne,
  output logic [7:0] shortSlotSecond,
  // Program counter control
  input wire cpu_core_pkg::pc_cmd_t pcCmd,
  output logic [11:0] pcOut,
  // Flags
  input wire cpu_core_pkg::flag_upd_t flagUpd,
  output logic carryOut,
  output logic zeroOut,
  output cpu_core_pkg::ctx_t ctxOut,
  // Stack state
  output logic stackEmpty,
  output logic [3:0] stackDepth
);
  generate
    if (STACK_DEPTH != cpu_core_pkg::STACK_LEVELS) begin : gBadStack
      $error("stack depth must stay at six levels");
    end
  endgenerate

  logic [7:0] acc_reg;
  logic [7:0] firstPointer_reg;
  logic [7:0] secondPointer_reg;
  logic [7:0] shortSlotOne_reg;
  logic [7:0] shortSlotSecond_reg;
  logic [11:0] pc_reg;
  logic [11:0] pc_next;
  logic [7:0] rdData_reg;
  logic rdHit_reg;
  logic [7:0] rdData_next;
  logic rdHit_next;
  logic stackPush;
  logic stackPop;
  logic [11:0] stackTop;
  logic isReturn;

  // ==========================================
  // Data-space registers
  // Bus write and ALU write in one cycle: ALU wins, it is the later stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg <= cpu_core_pkg::DATA_RESET;
    end else if (accWe) begin
      acc_reg <= accIn; // [RULE1]
    end else if (dsReq.wrEn && dsReq.addr == cpu_core_pkg::ADDR_ACCUMULATOR) begin
      acc_reg <= dsReq.wrData; // [RULE1]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      firstPointer_reg <= cpu_core_pkg::DATA_RESET;
      secondPointer_reg <= cpu_core_pkg::DATA_RESET;
      shortSlotOne_reg <= cpu_core_pkg::DATA_RESET;
      shortSlotSecond_reg <= cpu_core_pkg::DATA_RESET;
    end else if (dsReq.wrEn) begin
      unique case (dsReq.addr)
        cpu_core_pkg::ADDR_FIRST_POINTER: firstPointer_reg <= dsReq.wrData; // [RULE2]
        cpu_core_pkg::ADDR_SECOND_POINTER: secondPointer_reg <= dsReq.wrData; // [RULE2]
        cpu_core_pkg::ADDR_SHORT_SLOT_ONE: shortSlotOne_reg <= dsReq.wrData; // [RULE3]
        cpu_core_pkg::ADDR_SHORT_SLOT_SECOND: shortSlotSecond_reg <= dsReq.wrData; // [RULE3]
        default: ;
      endcase
    end
  end

  // ==========================================
  // Read path, one cycle of latency
  always_comb begin
    rdHit_next = 1'b1;
    unique case (dsReq.addr)
      cpu_core_pkg::ADDR_FIRST_POINTER: rdData_next = firstPointer_reg;
      cpu_core_pkg::ADDR_SECOND_POINTER: rdData_next = secondPointer_reg;
      cpu_core_pkg::ADDR_SHORT_SLOT_ONE: rdData_next = shortSlotOne_reg;
      cpu_core_pkg::ADDR_SHORT_SLOT_SECOND: rdData_next = shortSlotSecond_reg;
      cpu_core_pkg::ADDR_ACCUMULATOR: rdData_next = acc_reg;
      default: begin
        rdData_next = cpu_core_pkg::READ_MISS;
        rdHit_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_reg <= cpu_core_pkg::READ_MISS;
      rdHit_reg <= 1'b0;
    end else begin
      rdData_reg <= dsReq.rdEn ? rdData_next : cpu_core_pkg::READ_MISS;
      rdHit_reg <= dsReq.rdEn && rdHit_next;
    end
  end

  // ==========================================
  // Program counter
  // Twelve bits wrap at 4096; wider reach belongs to a bank register elsewhere
  assign isReturn = (pcCmd.op == cpu_core_pkg::PC_SUBRET) || (pcCmd.op == cpu_core_pkg::PC_INTRET);
  assign stackPush = (pcCmd.op == cpu_core_pkg::PC_CALL) || (pcCmd.op == cpu_core_pkg::PC_INTR); // [RULE15]
  assign stackPop = isReturn; // [RULE16]

  always_comb begin
    unique case (pcCmd.op)
      cpu_core_pkg::PC_HOLD: pc_next = pc_reg;
      cpu_core_pkg::PC_STEP: pc_next = pc_reg + cpu_core_pkg::PC_ONE; // [RULE6] [RULE5]
      cpu_core_pkg::PC_JUMP: pc_next = pcCmd.target; // [RULE7]
      cpu_core_pkg::PC_CALL: pc_next = pcCmd.target; // [RULE7]
      cpu_core_pkg::PC_REL: pc_next = pcCmd.target; // [RULE7]
      cpu_core_pkg::PC_INTR: pc_next = pcCmd.target; // [RULE7]
      // Empty stack: no pop, simply the next instruction
      cpu_core_pkg::PC_SUBRET, cpu_core_pkg::PC_INTRET:
        pc_next = stackEmpty ? pc_reg + cpu_core_pkg::PC_ONE : stackTop; // [RULE16] [RULE18]
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_reg <= cpu_core_pkg::RESET_VECTOR; // [RULE20] [RULE4]
    end else begin
      pc_reg <= pc_next; // [RULE7]
    end
  end

  // ==========================================
  // Stack and flag banks
  return_stack #(
    .DEPTH(STACK_DEPTH),
    .W(cpu_core_pkg::PC_W)
  ) uStack (
    .clk(clk),
    .rst_b(rst_b),
    .push(stackPush),
    .pop(stackPop),
    .pushData(pc_reg), // [RULE15]
    .top(stackTop),
    .empty(stackEmpty),
    .depth(stackDepth)
  );

  context_flags uFlags (
    .clk(clk),
    .rst_b(rst_b),
    .enterIrq(pcCmd.op == cpu_core_pkg::PC_INTR && !pcCmd.nmi), // [RULE9]
    .enterNmi(pcCmd.op == cpu_core_pkg::PC_INTR && pcCmd.nmi), // [RULE9]
    .exitCtx(pcCmd.op == cpu_core_pkg::PC_INTRET), // [RULE9]
    .upd(flagUpd),
    .ctx(ctxOut),
    .carry(carryOut),
    .zero(zeroOut)
  );

  assign accOut = acc_reg;
  assign firstPointer = firstPointer_reg;
  assign secondPointer = secondPointer_reg;
  assign shortSlotOne = shortSlotOne_reg;
  assign shortSlotSecond = shortSlotSecond_reg;
  assign pcOut = pc_reg;
  assign dsRdData = rdData_reg;
  assign dsRdHit = rdHit_reg;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence callThenReturn_s;
    (pcCmd.op == cpu_core_pkg::PC_CALL) ##1 (pcCmd.op == cpu_core_pkg::PC_SUBRET);
  endsequence
  sequence accBusWrite_s;
    dsReq.wrEn && !accWe && dsReq.addr == cpu_core_pkg::ADDR_ACCUMULATOR;
  endsequence

  pc_step_a: assert property (pcCmd.op == cpu_core_pkg::PC_STEP |=> pc_reg == $past(pc_reg) + 12'h001) // [RULE6]
    else $error("program counter did not advance by one");

  call_return_a: assert property (callThenReturn_s |=> pc_reg == $past(pc_reg, 2)) // [RULE16]
    else $error("return did not restore the call address");

  jump_load_a: assert property (pcCmd.op == cpu_core_pkg::PC_JUMP |=> pc_reg == $past(pcCmd.target)) // [RULE7]
    else $error("jump target not loaded");

  ret_empty_a: assert property ((isReturn && stackEmpty) |=> // [RULE18]
    stackEmpty && pc_reg == $past(pc_reg) + 12'h001)
    else $error("return on empty stack misbehaved");

  acc_bus_a: assert property (accBusWrite_s ##1 (dsReq.rdEn && dsReq.addr == cpu_core_pkg::ADDR_ACCUMULATOR) // [RULE1]
    |=> dsRdData == $past(dsReq.wrData, 2) && dsRdHit)
    else $error("accumulator not readable at its data-space address");

  ptr_write_a: assert property ((dsReq.wrEn && dsReq.addr == cpu_core_pkg::ADDR_SECOND_POINTER) // [RULE2]
    |=> secondPointer == $past(dsReq.wrData))
    else $error("second pointer write lost");

  slot_write_a: assert property ((dsReq.wrEn && dsReq.addr == cpu_core_pkg::ADDR_SHORT_SLOT_SECOND) // [RULE3]
    |=> shortSlotSecond == $past(dsReq.wrData))
    else $error("short slot write lost");

  intr_entry_a: assert property ((pcCmd.op == cpu_core_pkg::PC_INTR && pcCmd.nmi) // [RULE9]
    |=> ctxOut == cpu_core_pkg::CTX_NMI && pc_reg == $past(pcCmd.target) && !stackEmpty)
    else $error("NMI entry did not switch context and vector");

  miss_read_a: assert property ((dsReq.rdEn && dsReq.addr == 8'h84) |=> !dsRdHit && dsRdData == 8'h00) // [RULE1]
    else $error("unmapped read answered");

  // ==========================================
  // Further checks, one step each
  sequence noSwitch_s;
    pcCmd.op != cpu_core_pkg::PC_INTR && pcCmd.op != cpu_core_pkg::PC_INTRET;
  endsequence
  sequence irqEntry_s;
    pcCmd.op == cpu_core_pkg::PC_INTR && !pcCmd.nmi;
  endsequence

  acc_alu_a: assert property (accWe |=> accOut == $past(accIn)) // [RULE1]
    else $error("ALU accumulator write lost");

  ptr_first_a: assert property ((dsReq.wrEn && dsReq.addr == cpu_core_pkg::ADDR_FIRST_POINTER) // [RULE2]
    |=> firstPointer == $past(dsReq.wrData)) else $error("first pointer write lost");

  slot_first_a: assert property ((dsReq.wrEn && dsReq.addr == cpu_core_pkg::ADDR_SHORT_SLOT_ONE) // [RULE3]
    |=> shortSlotOne == $past(dsReq.wrData)) else $error("first short slot write lost");

  ptr_read_a: assert property ((dsReq.rdEn && dsReq.addr == cpu_core_pkg::ADDR_SECOND_POINTER) // [RULE2]
    |=> dsRdHit && dsRdData == $past(secondPointer_reg)) else $error("second pointer read wrong");

  slot_read_a: assert property ((dsReq.rdEn && dsReq.addr == cpu_core_pkg::ADDR_SHORT_SLOT_ONE) // [RULE3]
    |=> dsRdHit && dsRdData == $past(shortSlotOne_reg)) else $error("short slot read wrong");

  read_stands_a: assert property (!dsReq.rdEn |=> !dsRdHit && dsRdData == cpu_core_pkg::READ_MISS) // [RULE1]
    else $error("read answer stood too long");

  call_load_a: assert property (pcCmd.op == cpu_core_pkg::PC_CALL // [RULE15]
    |=> pc_reg == $past(pcCmd.target) && stackTop == $past(pc_reg)) else $error("call did not push and load");

  rel_load_a: assert property (pcCmd.op == cpu_core_pkg::PC_REL |=> pc_reg == $past(pcCmd.target)) // [RULE7]
    else $error("relative branch sum not loaded");

  pc_hold_a: assert property (pcCmd.op == cpu_core_pkg::PC_HOLD |=> $stable(pc_reg)) // [RULE7]
    else $error("program counter moved on hold");

  push_depth_a: assert property ((stackPush && stackDepth != 4'(cpu_core_pkg::STACK_LEVELS)) // [RULE15]
    |=> stackDepth == $past(stackDepth) + 4'h1) else $error("push did not deepen stack");

  pop_depth_a: assert property ((stackPop && !stackEmpty) |=> stackDepth == $past(stackDepth) - 4'h1) // [RULE16]
    else $error("pop did not shallow stack");

  depth_bound_a: assert property (stackDepth <= 4'(cpu_core_pkg::STACK_LEVELS)) // [RULE14]
    else $error("stack deeper than six levels");

  ret_pop_a: assert property ((isReturn && !stackEmpty) |=> pc_reg == $past(stackTop)) // [RULE16]
    else $error("return did not load level one");

  irq_entry_a: assert property (irqEntry_s |=> ctxOut == cpu_core_pkg::CTX_IRQ && pc_reg == $past(pcCmd.target)) // [RULE9]
    else $error("interrupt entry did not switch context and vector");

  flag_update_a: assert property ((flagUpd.carryWe && flagUpd.zeroWe) ##0 noSwitch_s // [RULE11] [RULE12]
    |=> carryOut == $past(flagUpd.carryIn) && zeroOut == $past(flagUpd.zeroIn)) else $error("active flags not updated");

  ctx_steady_a: assert property (noSwitch_s |=> ctxOut == $past(ctxOut)) // [RULE10]
    else $error("context changed without a switch");
endmodule

// ==== rtl/cpu_core_pkg.sv ====
// Shared constants and types of the CPU core register file
package cpu_core_pkg;
  // ==========================================
  // Widths and sizes
  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int STACK_LEVELS = 6;
  localparam int CTX_COUNT = 3;
  // ==========================================
  // Data-space offsets
  localparam logic [7:0] ADDR_FIRST_POINTER = 8'h80;
  localparam logic [7:0] ADDR_SECOND_POINTER = 8'h81;
  localparam logic [7:0] ADDR_SHORT_SLOT_ONE = 8'h82;
  localparam logic [7:0] ADDR_SHORT_SLOT_SECOND = 8'h83;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'hFF;
  // ==========================================
  // Values after reset, and the program counter step
  localparam logic [11:0] RESET_VECTOR = 12'hFFE;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] READ_MISS = 8'h00;
  localparam logic [11:0] PC_ONE = 12'h001;
  // ==========================================
  // Program counter sources and flag contexts
  typedef enum logic [2:0] {
    PC_HOLD, PC_STEP, PC_JUMP, PC_CALL, PC_REL, PC_INTR, PC_SUBRET, PC_INTRET
  } pc_op_t;
  typedef enum logic [1:0] {CTX_NORMAL, CTX_IRQ, CTX_NMI} ctx_t;
  typedef struct packed {
    pc_op_t op;
    logic [11:0] target;
    logic nmi;
  } pc_cmd_t;
  typedef struct packed {
    logic carryWe;
    logic carryIn;
    logic zeroWe;
    logic zeroIn;
  } flag_upd_t;
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } ds_req_t;
endpackage

// ==== rtl/return_stack.sv ====
// Six-level shift return stack without a pointer
`timescale 1ns/1ps
module return_stack #(
  parameter int DEPTH = 6,
  parameter int W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Stack operations
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] pushData,
  // State
  output logic [W-1:0] top,
  output logic empty,
  output logic [3:0] depth
);
  generate
    if (DEPTH < 2 || DEPTH > 15) begin : gBadDepth
      $error("return_stack depth out of range");
    end
  endgenerate

  logic [W-1:0] levels_reg [DEPTH];
  logic [3:0] depth_reg;

  // ==========================================
  // Level shifting
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : gLevel
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          levels_reg[gi] <= '0;
        end else if (push) begin
          // Deepest level simply falls off the end [RULE15]
          levels_reg[gi] <= (gi == 0) ? pushData : levels_reg[(gi == 0) ? 0 : gi - 1];
        end else if (pop && depth_reg != 4'h0) begin
          levels_reg[gi] <= (gi == DEPTH - 1) ? '0 : levels_reg[(gi == DEPTH - 1) ? gi : gi + 1]; // [RULE16]
        end
      end
    end
  endgenerate

  // ==========================================
  // Occupancy, saturating at both ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      depth_reg <= 4'h0; // [RULE20]
    end else if (push) begin
      if (depth_reg != 4'(DEPTH)) begin
        depth_reg <= depth_reg + 4'h1; // [RULE17]
      end
    end else if (pop && depth_reg != 4'h0) begin
      depth_reg <= depth_reg - 4'h1; // [RULE18]
    end
  end

  assign top = levels_reg[0];
  assign empty = (depth_reg == 4'h0);
  assign depth = depth_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  stack_saturate_a: assert property ((push && depth_reg == 4'(DEPTH)) |=> depth_reg == 4'(DEPTH)) // [RULE17]
    else $error("stack depth passed its deepest level");
  stack_lifo_a: assert property ((push && !pop) ##1 (pop && !push) |=> top == $past(levels_reg[0], 2)) // [RULE14]
    else $error("push then pop did not restore the old top");
endmodule

// ==== rtl/context_flags.sv ====
// Banked carry and zero flags with interrupt context chain
`timescale 1ns/1ps
module context_flags (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Context events
  input wire logic enterIrq,
  input wire logic enterNmi,
  input wire logic exitCtx,
  // Flag updates from the ALU
  input wire cpu_core_pkg::flag_upd_t upd,
  // Active state
  output cpu_core_pkg::ctx_t ctx,
  output logic carry,
  output logic zero
);
  cpu_core_pkg::ctx_t ctx_reg;
  cpu_core_pkg::ctx_t saved_reg [2];
  logic [1:0] savedCnt_reg;
  logic [2:0] carryBank_reg;
  logic [2:0] zeroBank_reg;
  logic [1:0] idx;

  assign idx = ctx_reg;

  // ==========================================
  // Context chain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctx_reg <= cpu_core_pkg::CTX_NMI; // [RULE13]
      saved_reg[0] <= cpu_core_pkg::CTX_NORMAL;
      saved_reg[1] <= cpu_core_pkg::CTX_NORMAL;
      savedCnt_reg <= 2'h0;
    end else if (enterIrq || enterNmi) begin
      ctx_reg <= enterNmi ? cpu_core_pkg::CTX_NMI : cpu_core_pkg::CTX_IRQ; // [RULE9]
      saved_reg[1] <= saved_reg[0];
      saved_reg[0] <= ctx_reg; // [RULE21]
      if (savedCnt_reg != 2'h2) begin
        savedCnt_reg <= savedCnt_reg + 2'h1;
      end
    end else if (exitCtx) begin
      // Empty chain falls back to the main program
      ctx_reg <= (savedCnt_reg != 2'h0) ? saved_reg[0] : cpu_core_pkg::CTX_NORMAL; // [RULE9] [RULE21]
      saved_reg[0] <= saved_reg[1];
      saved_reg[1] <= cpu_core_pkg::CTX_NORMAL;
      if (savedCnt_reg != 2'h0) begin
        savedCnt_reg <= savedCnt_reg - 2'h1;
      end
    end
  end

  // ==========================================
  // Flag banks, only the active pair is touched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      carryBank_reg <= 3'h0;
      zeroBank_reg <= 3'h0;
    end else begin
      if (upd.carryWe) begin
        carryBank_reg[idx] <= upd.carryIn; // [RULE8] [RULE10] [RULE11]
      end
      if (upd.zeroWe) begin
        zeroBank_reg[idx] <= upd.zeroIn; // [RULE12]
      end
    end
  end

  assign ctx = ctx_reg;
  assign carry = carryBank_reg[idx]; // [RULE10]
  assign zero = zeroBank_reg[idx];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence nmiOverIrq_s;
    (enterIrq && !enterNmi) ##1 (enterNmi && !enterIrq) ##1 (exitCtx && !enterIrq && !enterNmi);
  endsequence
  chain_return_a: assert property (nmiOverIrq_s |=> ctx_reg == cpu_core_pkg::CTX_IRQ) // [RULE21]
    else $error("exit from nested NMI did not reselect interrupt pair");
  flags_kept_a: assert property ((ctx_reg != cpu_core_pkg::CTX_NORMAL && !upd.carryWe) |=> // [RULE10]
    carryBank_reg[0] == $past(carryBank_reg[0]))
    else $error("main carry changed outside its context");
endmodule

// ==== dv/seq_model.sv ====
// Sequencer and ALU stand-in driving the control side of the register file
`timescale 1ns/1ps
module seq_model (
  // Clock
  input wire logic clk,
  // Requests toward the register file
  output cpu_core_pkg::ds_req_t dsReq,
  output logic accWe,
  output logic [7:0] accIn,
  output cpu_core_pkg::pc_cmd_t pcCmd,
  output cpu_core_pkg::flag_upd_t flagUpd
);
  initial begin
    dsReq = '0;
    accWe = 1'b0;
    accIn = 8'h00;
    pcCmd = '0;
    flagUpd = '0;
  end
  // ==========================================
  // One machine cycle: launched after an edge, held until the next edge takes it
  // Strobes are single-cycle, so every call relaunches all lines at once
  task automatic cyc(input cpu_core_pkg::pc_cmd_t c, input cpu_core_pkg::flag_upd_t u,
                     input cpu_core_pkg::ds_req_t r, input logic aWe, input logic [7:0] aIn);
    pcCmd <= c;
    flagUpd <= u;
    dsReq <= r;
    accWe <= aWe;
    accIn <= aIn;
    @(posedge clk);
  endtask
endmodule

// ==== dv/cpu_core_registers_tb_top.sv ====
// Self-checking bench for the core registers, program counter, banked flags and stack
`timescale 1ns/1ps
module cpu_core_registers_tb_top;
  typedef struct packed {
    logic [11:0] pc;
    cpu_core_pkg::ctx_t ctx;
    logic carry;
    logic zero;
    logic empty;
    logic [3:0] depth;
    logic [4:0][7:0] regs;
  } state_t;
  typedef struct packed {
    logic hit;
    logic [7:0] data;
  } rd_note_t;
  logic clk;
  logic rst_b;
  cpu_core_pkg::ds_req_t dsReq;
  cpu_core_pkg::pc_cmd_t pcCmd;
  cpu_core_pkg::flag_upd_t flagUpd;
  cpu_core_pkg::ctx_t ctxOut;
  logic accWe;
  logic [7:0] accIn;
  logic [7:0] dsRdData;
  logic dsRdHit;
  logic [4:0][7:0] regsOut;
  logic [11:0] pcOut;
  logic carryOut;
  logic zeroOut;
  logic stackEmpty;
  logic [3:0] stackDepth;
  state_t stateQ[$];
  rd_note_t readQ[$];
  int err_total;
  int n_compared;
  // ==========================================
  // Reference state kept from the rules
  logic [11:0] mPc;
  cpu_core_pkg::ctx_t mCtx;
  cpu_core_pkg::ctx_t chain[$];
  logic [11:0] stk[$];
  logic [2:0] mCarry;
  logic [2:0] mZero;
  logic [4:0][7:0] mRegs;
  logic [7:0] amap [6] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'h84};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  seq_model u_seq (.clk(clk), .dsReq(dsReq), .accWe(accWe), .accIn(accIn), .pcCmd(pcCmd), .flagUpd(flagUpd));

  cpu_core_registers #(.STACK_DEPTH(cpu_core_pkg::STACK_LEVELS)) u_dut (
    .clk(clk), .rst_b(rst_b), .dsReq(dsReq), .dsRdData(dsRdData), .dsRdHit(dsRdHit),
    .accWe(accWe), .accIn(accIn), .accOut(regsOut[4]), .firstPointer(regsOut[0]),
    .secondPointer(regsOut[1]), .shortSlotOne(regsOut[2]), .shortSlotSecond(regsOut[3]),
    .pcCmd(pcCmd), .pcOut(pcOut), .flagUpd(flagUpd), .carryOut(carryOut), .zeroOut(zeroOut),
    .ctxOut(ctxOut), .stackEmpty(stackEmpty), .stackDepth(stackDepth));

  function automatic int slot(input logic [7:0] a);
    for (int i = 0; i < 5; i++) begin
      if (amap[i] == a) return i;
    end
    return -1;
  endfunction

  task automatic cmp_state(input state_t e);
    state_t o;
    o = '{pcOut, ctxOut, carryOut, zeroOut, stackEmpty, stackDepth, regsOut};
    n_compared++;
    if (o !== e) begin
      err_total++;
      $display("BAD %0t state got %h expected %h", $time, o, e);
    end
  endtask

  task automatic cmp_read(input rd_note_t e);
    n_compared++;
    if ({dsRdHit, dsRdData} !== e) begin
      err_total++;
      $display("BAD %0t read got %h expected %h", $time, {dsRdHit, dsRdData}, e);
    end
  endtask

  // ==========================================
  // Watcher: oldest note against what the outputs show after each taking edge
  always @(posedge clk) begin
    #1;
    if (rst_b === 1'b1 && stateQ.size() > 0) cmp_state(stateQ.pop_front());
    if (rst_b === 1'b1 && readQ.size() > 0) cmp_read(readQ.pop_front());
  end

  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One cycle of stimulus; the read is noted before the reference is stepped, so reads see old bytes
  task automatic op(input cpu_core_pkg::pc_op_t o, input logic [11:0] t, input logic nmi,
                    input cpu_core_pkg::flag_upd_t fu, input logic wrE, input logic rdE,
                    input logic [7:0] a, input logic [7:0] d, input logic aWe, input logic [7:0] aIn);
    rd_note_t rn;
    state_t es;
    int s;
    s = slot(a);
    rn = '0;
    if (rdE && s >= 0) rn = '{1'b1, mRegs[s]};
    if (wrE && s >= 0 && !(s == 4 && aWe)) mRegs[s] = d;
    if (aWe) mRegs[4] = aIn;
    if (fu.carryWe) mCarry[mCtx] = fu.carryIn;
    if (fu.zeroWe) mZero[mCtx] = fu.zeroIn;
    if (o == cpu_core_pkg::PC_STEP) mPc = mPc + 12'h001;
    if (o == cpu_core_pkg::PC_JUMP || o == cpu_core_pkg::PC_REL) mPc = t;
    if (o == cpu_core_pkg::PC_CALL || o == cpu_core_pkg::PC_INTR) begin
      stk.push_front(mPc);
      if (stk.size() > cpu_core_pkg::STACK_LEVELS) void'(stk.pop_back());
      mPc = t;
    end
    if (o == cpu_core_pkg::PC_INTR) begin
      chain.push_back(mCtx);
      mCtx = nmi ? cpu_core_pkg::CTX_NMI : cpu_core_pkg::CTX_IRQ;
    end
    if (o == cpu_core_pkg::PC_SUBRET || o == cpu_core_pkg::PC_INTRET) begin
      if (stk.size() > 0) mPc = stk.pop_front();
      else mPc = mPc + 12'h001;
    end
    if (o == cpu_core_pkg::PC_INTRET) mCtx = chain.size() > 0 ? chain.pop_back() : cpu_core_pkg::CTX_NORMAL;
    es = '{mPc, mCtx, mCarry[mCtx], mZero[mCtx], stk.size() == 0, 4'(stk.size()), mRegs};
    u_seq.cyc('{o, t, nmi}, fu, '{wrE, rdE, a, d}, aWe, aIn);
    stateQ.push_back(es);
    readQ.push_back(rn);
  endtask

  task automatic pc(input cpu_core_pkg::pc_op_t o, input logic [11:0] t, input logic nmi);
    op(o, t, nmi, '0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00);
  endtask

  task automatic fl(input logic c, input logic z);
    op(cpu_core_pkg::PC_HOLD, 12'h000, 1'b0, '{1'b1, c, 1'b1, z}, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00);
  endtask

  task automatic bus(input logic wrE, input logic [7:0] a, input logic [7:0] d);
    op(cpu_core_pkg::PC_HOLD, 12'h000, 1'b0, '0, wrE, !wrE, a, d, 1'b0, 8'h00);
  endtask

  task automatic do_reset;
    u_seq.cyc('0, '0, '0, 1'b0, 8'h00);
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    stateQ.delete();
    readQ.delete();
    mPc = cpu_core_pkg::RESET_VECTOR;
    mCtx = cpu_core_pkg::CTX_NMI;
    chain.delete();
    stk.delete();
    mCarry = '0;
    mZero = '0;
    mRegs = '0;
    rst_b <= 1'b1;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    cpu_core_pkg::pc_op_t o;
    logic nm;
    int r;
    rst_b = 1'b0;
    err_total = 0;
    n_compared = 0;
    void'($urandom(32'hF1679008));
    do_reset();
    pc(cpu_core_pkg::PC_STEP, 12'h000, 1'b0);
    pc(cpu_core_pkg::PC_STEP, 12'h000, 1'b0);
    for (int i = 0; i < 6; i++) bus(1'b1, amap[i], 8'($urandom));
    for (int i = 0; i < 6; i++) bus(1'b0, amap[i], 8'h00);
    // Bus and ALU write the accumulator together; the ALU value must stand
    op(cpu_core_pkg::PC_HOLD, 12'h000, 1'b0, '0, 1'b1, 1'b0, 8'hFF, 8'hA5, 1'b1, 8'h3C);
    bus(1'b0, 8'hFF, 8'h00);
    fl(1'b1, 1'b0);
    pc(cpu_core_pkg::PC_INTRET, 12'h000, 1'b0);
    fl(1'b0, 1'b1);
    pc(cpu_core_pkg::PC_INTR, 12'hFF0, 1'b0);
    fl(1'b1, 1'b1);
    pc(cpu_core_pkg::PC_INTR, 12'hFFC, 1'b1);
    pc(cpu_core_pkg::PC_INTRET, 12'h000, 1'b0);
    pc(cpu_core_pkg::PC_INTRET, 12'h000, 1'b0);
    // Calls save only return addresses, so the accumulator is parked by hand
    bus(1'b1, cpu_core_pkg::ADDR_SHORT_SLOT_ONE, mRegs[4]);
    for (int i = 0; i < 7; i++) pc(cpu_core_pkg::PC_CALL, 12'($urandom), 1'b0);
    for (int i = 0; i < 8; i++) pc(cpu_core_pkg::PC_SUBRET, 12'h000, 1'b0);
    bus(1'b0, cpu_core_pkg::ADDR_SHORT_SLOT_ONE, 8'h00);
    for (int i = 0; i < 400; i++) begin
      o = cpu_core_pkg::pc_op_t'($urandom_range(0, 7));
      nm = 1'($urandom);
      // Nesting limited to what the core can take: irq in main, nmi in main or irq
      if (o == cpu_core_pkg::PC_INTR && !(mCtx == cpu_core_pkg::CTX_NORMAL || (mCtx == cpu_core_pkg::CTX_IRQ && nm))) o = cpu_core_pkg::PC_STEP;
      r = $urandom_range(0, 2);
      op(o, 12'($urandom), nm, cpu_core_pkg::flag_upd_t'(4'($urandom)), r == 1, r == 2,
         amap[$urandom_range(0, 5)], 8'($urandom), 1'($urandom), 8'($urandom));
    end
    do_reset();
    pc(cpu_core_pkg::PC_SUBRET, 12'h000, 1'b0);
    for (int i = 0; i < 5; i++) bus(1'b0, amap[i], 8'h00);
    pc(cpu_core_pkg::PC_HOLD, 12'h000, 1'b0);
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule
